/* File: hw/tcv_map.svh */
// Register offsets, field positions and reset values of the timer channel block.
// Assumes byte addresses on a 32-bit bus, one aligned word per register.
`ifndef TCV_MAP_SVH
`define TCV_MAP_SVH

`define TCV_CTRL_OFF 12'h000
`define TCV_CHCS_BASE 12'h00c
`define TCV_CNV_BASE 12'h010
`define TCV_CH_STRIDE 12'h008
`define TCV_STATUS_OFF 12'h050
`define TCV_TIMER_SETUP_OFF 12'h084
`define TCV_ADDR_W 12

`define TCV_CHF_BIT 7
`define TCV_WRAP_CTRL_BIT 7
`define TCV_WRAP_STAT_BIT 8
`define TCV_MODE_LSB 2
`define TCV_MODE_MSB 3
`define TCV_TRG_LSB 24
`define TCV_TRG_MSB 27

`define TCV_VAL_RESET 16'h0000
`define TCV_TRG_RESET 4'h0

`endif

/* File: hw/tcv_pkg.sv */
// Types shared by the timer channel block.
// Assumes tcv_map.svh supplies the offsets and field positions.
`default_nettype none

package tcv_pkg;

    // Channel operating mode, held in the channel control/status word
    typedef enum logic [1:0] {
        TCV_MODE_OFF,
        TCV_MODE_CAPTURE,
        TCV_MODE_COMPARE,
        TCV_MODE_PWM
    } tcv_mode_t;

endpackage : tcv_pkg

`default_nettype wire

/* File: hw/tcv_chan_slot.sv */
// One channel value slot: active value register plus compare write buffer.
// Assumes the parent qualifies writes and capture events for this channel.
`timescale 1ns/1ps
`default_nettype none
`include "tcv_map.svh"

module tcv_chan_slot #(
    parameter int VAL_W = 16
) (
    input wire logic clk_i,                        // Module clock
    input wire logic reset_i,                      // Synchronous reset, high
    input wire tcv_pkg::tcv_mode_t mode_i,         // Channel mode
    input wire logic capture_i,                    // Capture event pulse
    input wire logic [VAL_W-1:0] counter_i,        // Live counter value
    input wire logic wr_i,                         // Software write pulse
    input wire logic [VAL_W-1:0] wdata_i,          // Software write data
    input wire logic update_i,                     // Counter update point
    output logic [VAL_W-1:0] value_o               // Active value, registered
);

    logic [VAL_W-1:0] value_q;
    logic [VAL_W-1:0] value_d;
    logic [VAL_W-1:0] buf_q;
    logic [VAL_W-1:0] buf_d;
    logic is_capture;
    logic is_compare;

    assign is_capture = (mode_i == tcv_pkg::TCV_MODE_CAPTURE);
    assign is_compare = (mode_i == tcv_pkg::TCV_MODE_COMPARE) || (mode_i == tcv_pkg::TCV_MODE_PWM);

    // Capture mode drops writes; off mode fills the buffer too, so a later
    // update point after switching to compare never restores a stale word
    assign buf_d = (wr_i && !is_capture) ? wdata_i : buf_q;

    // Buffered value moves at the update point so a period never sees half a change
    assign value_d = (is_capture && capture_i) ? counter_i :
                     (is_compare && update_i) ? buf_q :
                     (wr_i && !is_capture && !is_compare) ? wdata_i :
                     value_q;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            value_q <= VAL_W'(`TCV_VAL_RESET);
            buf_q <= VAL_W'(`TCV_VAL_RESET);
        end else begin
            value_q <= value_d;
            buf_q <= buf_d;
        end
    end

    assign value_o = value_q;

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    property p_compare_write_buffered;
        is_compare && wr_i && !update_i |=> value_q == $past(value_q) && buf_q == $past(wdata_i);
    endproperty
    a_compare_write_buffered: assert property (p_compare_write_buffered)
        else $error("compare write reached active value directly");

    property p_update_loads;
        is_compare && update_i |=> value_q == $past(buf_q);
    endproperty
    a_update_loads: assert property (p_update_loads)
        else $error("update point did not load buffered value");

    property p_capture_takes_counter;
        is_capture && capture_i |=> value_q == $past(counter_i);
    endproperty
    a_capture_takes_counter: assert property (p_capture_takes_counter)
        else $error("capture event did not store counter value");

endmodule : tcv_chan_slot

`default_nettype wire

/* File: hw/tcv_top.sv */
// Timer channel value, status and trigger-select registers behind AHB-Lite.
// Assumes counter, capture edges and compare matches are produced outside
// and arrive as synchronous pulses on this clock.
`timescale 1ns/1ps
`default_nettype none
`include "tcv_map.svh"

module tcv_top #(
    parameter int NUM_CH = 6,
    parameter int VAL_W = 16
) (
    input wire logic clk_i,                            // Module clock, 100 MHz
    input wire logic reset_i,                          // Synchronous reset, high
    input wire logic hsel_i,                           // AHB slave select
    input wire logic [31:0] haddr_i,                   // AHB address
    input wire logic [1:0] htrans_i,                   // AHB transfer type
    input wire logic hwrite_i,                         // AHB write
    input wire logic [2:0] hsize_i,                    // AHB size
    input wire logic [31:0] hwdata_i,                  // AHB write data
    input wire logic hready_i,                         // AHB bus ready
    output logic [31:0] hrdata_o,                      // AHB read data
    output logic hreadyout_o,                          // AHB slave ready
    output logic hresp_o,                              // AHB response, always OKAY
    input wire logic [VAL_W-1:0] counter_value_i,      // Live counter value
    input wire logic [NUM_CH-1:0] chan_event_i,        // Channel event pulses
    input wire logic counter_wrap_i,                   // Counter overflow pulse
    input wire logic update_point_i,                   // Counter update point pulse
    output logic [NUM_CH*VAL_W-1:0] match_value_o,     // Active channel values
    output logic [2*NUM_CH-1:0] channel_mode_o,        // Channel modes
    output logic [NUM_CH-1:0] channel_event_flag_o,    // Channel event flags
    output logic counter_wrap_flag_o,                  // Counter wrap flag
    output logic [3:0] trigger_source_select_o         // Trigger input select
);

    ////////////////////////////////////////////////////////////////////////////
    // Parameter checks

    if (NUM_CH < 1 || NUM_CH > 6) begin : g_bad_ch
        $error("NUM_CH must be 1 to 6, status has six channel bits");
    end
    if (VAL_W < 1 || VAL_W > 16) begin : g_bad_w
        $error("VAL_W must be 1 to 16, the value field is bits 15-0");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Address decode helper

    // True when addr is the word at base plus ch strides
    function automatic logic chan_hit(input logic [`TCV_ADDR_W-1:0] addr,
                                      input logic [`TCV_ADDR_W-1:0] base,
                                      input int ch);
        logic [`TCV_ADDR_W-1:0] target;
        target = base + `TCV_ADDR_W'(ch) * `TCV_CH_STRIDE;
        return addr == target;
    endfunction : chan_hit

    ////////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave front end

    logic acc_take;
    logic acc_rd;
    logic acc_wr;
    logic wr_pend_q;
    logic [`TCV_ADDR_W-1:0] wr_addr_q;
    logic [`TCV_ADDR_W-1:0] rd_addr;
    logic [31:0] rdata_d;
    logic [31:0] hrdata_q;
    logic hreadyout_q;
    logic hresp_q;

    assign acc_take = hsel_i && htrans_i[1] && hready_i;
    assign acc_rd = acc_take && !hwrite_i;
    assign acc_wr = acc_take && hwrite_i;
    assign rd_addr = haddr_i[`TCV_ADDR_W-1:0];

    // Zero wait states: read data are prepared from the address phase
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= '0;
            hrdata_q <= 32'h0000_0000;
            hreadyout_q <= 1'b1;
            hresp_q <= 1'b0;
        end else begin
            wr_pend_q <= acc_wr;
            wr_addr_q <= acc_wr ? haddr_i[`TCV_ADDR_W-1:0] : wr_addr_q;
            hrdata_q <= acc_rd ? rdata_d : 32'h0000_0000;
            hreadyout_q <= 1'b1;
            hresp_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Write strobes, taken in the data phase

    logic wr_ctrl;
    logic wr_status;
    logic wr_timer_setup;
    logic [NUM_CH-1:0] wr_chcs;
    logic [NUM_CH-1:0] wr_cnv;

    assign wr_ctrl = wr_pend_q && (wr_addr_q == `TCV_CTRL_OFF);
    assign wr_status = wr_pend_q && (wr_addr_q == `TCV_STATUS_OFF);
    assign wr_timer_setup = wr_pend_q && (wr_addr_q == `TCV_TIMER_SETUP_OFF);

    ////////////////////////////////////////////////////////////////////////////
    // Channels

    tcv_pkg::tcv_mode_t mode_q [NUM_CH];
    logic [NUM_CH-1:0] chf_q;
    logic [NUM_CH-1:0] chf_d;
    logic [NUM_CH-1:0] chf_clr;
    logic [VAL_W-1:0] slot_val [NUM_CH];
    logic [31:0] rd_chcs [NUM_CH];
    logic [31:0] rd_cnv [NUM_CH];

    for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
        logic capture_ev;

        assign wr_chcs[i] = wr_pend_q && chan_hit(wr_addr_q, `TCV_CHCS_BASE, i);
        assign wr_cnv[i] = wr_pend_q && chan_hit(wr_addr_q, `TCV_CNV_BASE, i);

        // Either the status word or the channel's own word may clear it
        assign chf_clr[i] = (wr_status && hwdata_i[i]) ||
                            (wr_chcs[i] && hwdata_i[`TCV_CHF_BIT]);
        // Set beats clear, so an event racing the write is never lost
        assign chf_d[i] = chan_event_i[i] || (chf_q[i] && !chf_clr[i]);

        assign capture_ev = chan_event_i[i] && (mode_q[i] == tcv_pkg::TCV_MODE_CAPTURE);

        always_ff @(posedge clk_i) begin
            if (reset_i) begin
                mode_q[i] <= tcv_pkg::TCV_MODE_OFF;
                chf_q[i] <= 1'b0;
            end else begin
                mode_q[i] <= wr_chcs[i] ?
                    tcv_pkg::tcv_mode_t'(hwdata_i[`TCV_MODE_MSB:`TCV_MODE_LSB]) : mode_q[i];
                chf_q[i] <= chf_d[i];
            end
        end

        // Upper half of the write data never reaches the slot
        tcv_chan_slot #(
            .VAL_W(VAL_W)
        ) u_slot (
            .clk_i(clk_i),
            .reset_i(reset_i),
            .mode_i(mode_q[i]),
            .capture_i(capture_ev),
            .counter_i(counter_value_i),
            .wr_i(wr_cnv[i]),
            .wdata_i(hwdata_i[VAL_W-1:0]),
            .update_i(update_point_i),
            .value_o(slot_val[i])
        );

        always_comb begin
            rd_chcs[i] = 32'h0000_0000;
            rd_chcs[i][`TCV_CHF_BIT] = chf_q[i];
            rd_chcs[i][`TCV_MODE_MSB:`TCV_MODE_LSB] = mode_q[i];
            rd_cnv[i] = 32'h0000_0000;
            rd_cnv[i][VAL_W-1:0] = slot_val[i];
        end

        assign match_value_o[i*VAL_W +: VAL_W] = slot_val[i];
        assign channel_mode_o[2*i +: 2] = mode_q[i];
    end

    ////////////////////////////////////////////////////////////////////////////
    // Counter wrap flag and trigger select

    logic wrap_q;
    logic wrap_clr;
    logic [3:0] trg_q;

    assign wrap_clr = (wr_ctrl && hwdata_i[`TCV_WRAP_CTRL_BIT]) ||
                      (wr_status && hwdata_i[`TCV_WRAP_STAT_BIT]);

    // Trigger select is taken at any time; changing it while counting is software's risk
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            wrap_q <= 1'b0;
            trg_q <= `TCV_TRG_RESET;
        end else begin
            wrap_q <= counter_wrap_i || (wrap_q && !wrap_clr);
            trg_q <= wr_timer_setup ? hwdata_i[`TCV_TRG_MSB:`TCV_TRG_LSB] : trg_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read mux

    logic [31:0] rd_status;
    logic [31:0] rd_timer_setup;
    logic [31:0] rd_ctrl;
    logic [31:0] rd_chan;

    always_comb begin
        rd_status = 32'h0000_0000;
        rd_status[NUM_CH-1:0] = chf_q;
        rd_status[`TCV_WRAP_STAT_BIT] = wrap_q;
        rd_timer_setup = 32'h0000_0000;
        rd_timer_setup[`TCV_TRG_MSB:`TCV_TRG_LSB] = trg_q;
        rd_ctrl = 32'h0000_0000;
        rd_ctrl[`TCV_WRAP_CTRL_BIT] = wrap_q;
        rd_chan = 32'h0000_0000;
        for (int i = 0; i < NUM_CH; i++) begin
            if (chan_hit(rd_addr, `TCV_CHCS_BASE, i)) begin
                rd_chan = rd_chan | rd_chcs[i];
            end else if (chan_hit(rd_addr, `TCV_CNV_BASE, i)) begin
                rd_chan = rd_chan | rd_cnv[i];
            end
        end
    end

    // Unmapped words read zero with an OKAY answer
    assign rdata_d = (rd_addr == `TCV_STATUS_OFF) ? rd_status :
                     (rd_addr == `TCV_TIMER_SETUP_OFF) ? rd_timer_setup :
                     (rd_addr == `TCV_CTRL_OFF) ? rd_ctrl :
                     rd_chan;

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign hrdata_o = hrdata_q;
    assign hreadyout_o = hreadyout_q;
    assign hresp_o = hresp_q;
    assign channel_event_flag_o = chf_q;
    assign counter_wrap_flag_o = wrap_q;
    assign trigger_source_select_o = trg_q;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    property p_status_mirror;
        acc_rd && (rd_addr == `TCV_STATUS_OFF) |=>
            hrdata_o[NUM_CH-1:0] == $past(chf_q) && hrdata_o[8] == $past(wrap_q);
    endproperty
    a_status_mirror: assert property (p_status_mirror)
        else $error("status read does not mirror the flags");

    property p_status_reserved;
        acc_rd && (rd_addr == `TCV_STATUS_OFF) |=> hrdata_o[31:9] == 23'h0 && hrdata_o[7:6] == 2'h0;
    endproperty
    a_status_reserved: assert property (p_status_reserved)
        else $error("status reserved bits not zero");

    property p_timer_setup_read;
        acc_rd && (rd_addr == `TCV_TIMER_SETUP_OFF) |=>
            hrdata_o[23:19] == 5'h00 && hrdata_o[27:24] == $past(trg_q);
    endproperty
    a_timer_setup_read: assert property (p_timer_setup_read)
        else $error("setup word read wrong");

    property p_trg_write;
        wr_timer_setup |=> trigger_source_select_o == $past(hwdata_i[27:24]);
    endproperty
    a_trg_write: assert property (p_trg_write)
        else $error("trigger select not stored");

    property p_all_ones_clear;
        wr_status && (hwdata_i == 32'hffff_ffff) && (chan_event_i == '0) |=> chf_q == '0;
    endproperty
    a_all_ones_clear: assert property (p_all_ones_clear)
        else $error("all-ones write left a channel flag set");

    property p_event_sets;
        chan_event_i[0] |=> chf_q[0] ##1 (chf_q[0] || $past(chf_clr[0]));
    endproperty
    a_event_sets: assert property (p_event_sets)
        else $error("channel event did not set its flag");

    property p_zero_write_keeps;
        chf_q[0] && wr_status && !hwdata_i[0] |=> chf_q[0];
    endproperty
    a_zero_write_keeps: assert property (p_zero_write_keeps)
        else $error("writing zero cleared a flag");

    property p_capture_ignores_write;
        wr_cnv[0] && (mode_q[0] == tcv_pkg::TCV_MODE_CAPTURE) && !chan_event_i[0] |=>
            slot_val[0] == $past(slot_val[0]);
    endproperty
    a_capture_ignores_write: assert property (p_capture_ignores_write)
        else $error("write changed a capture-mode value");

    property p_cnv_upper_zero;
        acc_rd && chan_hit(rd_addr, `TCV_CNV_BASE, 0) |=>
            hrdata_o[31:16] == 16'h0000 && hrdata_o[VAL_W-1:0] == $past(slot_val[0]);
    endproperty
    a_cnv_upper_zero: assert property (p_cnv_upper_zero)
        else $error("channel value read wrong");

    property p_bus_okay;
        hreadyout_o && !hresp_o;
    endproperty
    a_bus_okay: assert property (p_bus_okay)
        else $error("slave stalled or answered with an error");

    property p_wrap_sets;
        counter_wrap_i |=> counter_wrap_flag_o;
    endproperty
    a_wrap_sets: assert property (p_wrap_sets)
        else $error("counter wrap did not set the wrap flag");

    property p_one_clears;
        chf_q[0] && wr_status && hwdata_i[0] && !chan_event_i[0] |=> !chf_q[0];
    endproperty
    a_one_clears: assert property (p_one_clears)
        else $error("writing one to status did not clear the flag");

    property p_chan_word_clear;
        chf_q[NUM_CH-1] && wr_chcs[NUM_CH-1] && hwdata_i[`TCV_CHF_BIT] && !chan_event_i[NUM_CH-1]
            |=> !chf_q[NUM_CH-1];
    endproperty
    a_chan_word_clear: assert property (p_chan_word_clear)
        else $error("writing one to the channel word did not clear the flag");

    property p_race_keeps;
        chan_event_i[0] && wr_status && hwdata_i[0] |=> chf_q[0];
    endproperty
    a_race_keeps: assert property (p_race_keeps)
        else $error("clearing write beat a fresh event");

    property p_wrap_clear;
        wrap_q && wr_ctrl && hwdata_i[`TCV_WRAP_CTRL_BIT] && !counter_wrap_i |=> !wrap_q;
    endproperty
    a_wrap_clear: assert property (p_wrap_clear)
        else $error("writing one did not clear the wrap flag");

    property p_rdata_idle;
        !acc_rd |=> hrdata_o == 32'h0000_0000;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data not zero outside a read data phase");

endmodule : tcv_top

`default_nettype wire

/* File: testbench/tcv_tb.sv */
// Self-checking bench for the timer channel value, status and setup block.
// Assumes a single AHB-Lite slave with no wait states and pulse event inputs.
`timescale 1ns/1ps
`default_nettype none
`include "tcv_map.svh"

`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin n_fail++; \
    $display("[ERR] %0t got %h exp %h", $time, (got), (exp)); end end

module testbench;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [31:0] haddr_i = 32'h0000_0000;
    logic [1:0] htrans_i = 2'h0;
    logic hwrite_i = 1'b0;
    logic [31:0] hwdata_i = 32'h0000_0000;
    logic [15:0] counter_value_i = 16'h0000;
    logic [5:0] chan_event_i = 6'h00;
    logic counter_wrap_i = 1'b0;
    logic update_point_i = 1'b0;
    wire logic [31:0] hrdata_o;
    wire logic hreadyout_o;
    wire logic hready_i;
    wire logic hresp_o;
    wire logic [95:0] match_value_o;
    wire logic [11:0] channel_mode_o;
    wire logic [5:0] channel_event_flag_o;
    wire logic counter_wrap_flag_o;
    wire logic [3:0] trigger_source_select_o;
    int n_fail = 0;
    int n_checks = 0;
    logic [31:0] rd;

    // One slave on the bus, so its ready is the bus ready
    assign hready_i = hreadyout_o;

    always #5 clk_i = ~clk_i;

    tcv_top u_tcv_top (
        .clk_i(clk_i), .reset_i(reset_i), .hsel_i(1'b1), .haddr_i(haddr_i),
        // Whole-word transfers only, so both value bytes go in one access
        .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2),
        .hwdata_i(hwdata_i), .hready_i(hready_i), .hrdata_o(hrdata_o),
        .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
        .counter_value_i(counter_value_i), .chan_event_i(chan_event_i),
        .counter_wrap_i(counter_wrap_i), .update_point_i(update_point_i),
        .match_value_o(match_value_o), .channel_mode_o(channel_mode_o),
        .channel_event_flag_o(channel_event_flag_o),
        .counter_wrap_flag_o(counter_wrap_flag_o),
        .trigger_source_select_o(trigger_source_select_o)
    );

    ////////////////////////////////////////////////////////////////////////////////
    task automatic wrap_up;
        if (n_fail == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : wrap_up

    // Bounded wait for ready at a rising edge; a hang ends the run
    task automatic wait_rdy;
        int n;
        n = 0;
        @(posedge clk_i);
        while (hready_i !== 1'b1) begin
            n++;
            if (n > 100) begin
                n_fail++;
                wrap_up();
            end
            @(posedge clk_i);
        end
    endtask : wait_rdy

    // Events given in ev land in the data phase, alongside the write data
    task automatic ahb_write(input logic [11:0] a, input logic [31:0] d, input logic [5:0] ev);
        @(posedge clk_i);
        haddr_i <= {20'h00000, a};
        htrans_i <= 2'h2;
        hwrite_i <= 1'b1;
        wait_rdy();
        htrans_i <= 2'h0;
        hwdata_i <= d;
        chan_event_i <= ev;
        wait_rdy();
        chan_event_i <= 6'h00;
        #1;
    endtask : ahb_write

    task automatic ahb_read(input logic [11:0] a, output logic [31:0] d);
        @(posedge clk_i);
        haddr_i <= {20'h00000, a};
        htrans_i <= 2'h2;
        hwrite_i <= 1'b0;
        wait_rdy();
        htrans_i <= 2'h0;
        wait_rdy();
        d = hrdata_o;
        #1;
    endtask : ahb_read

    task automatic pulse(input logic [5:0] ev, input logic wrap, input logic upd);
        @(posedge clk_i);
        chan_event_i <= ev;
        counter_wrap_i <= wrap;
        update_point_i <= upd;
        @(posedge clk_i);
        chan_event_i <= 6'h00;
        counter_wrap_i <= 1'b0;
        update_point_i <= 1'b0;
        #1;
    endtask : pulse

    function automatic logic [11:0] channel_value_reg(input int ch);
        return `TCV_CNV_BASE + `TCV_CH_STRIDE * 12'(ch);
    endfunction : channel_value_reg

    function automatic logic [11:0] chcs(input int ch);
        return `TCV_CHCS_BASE + `TCV_CH_STRIDE * 12'(ch);
    endfunction : chcs

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset_values;
        ahb_read(channel_value_reg(0), rd);
        `CHK(rd, 32'h0000_0000)
        ahb_read(`TCV_STATUS_OFF, rd);
        `CHK(rd, 32'h0000_0000)
        ahb_read(`TCV_TIMER_SETUP_OFF, rd);
        `CHK(rd, 32'h0000_0000)
        ahb_read(12'h0fc, rd);
        `CHK(rd, 32'h0000_0000)
        `CHK(hresp_o, 1'b0)
        `CHK(hreadyout_o, 1'b1)
    endtask : t_reset_values

    // Captured count lands in the value word; software writes are dropped
    task automatic t_capture;
        ahb_write(chcs(0), 32'(tcv_pkg::TCV_MODE_CAPTURE) << `TCV_MODE_LSB, 6'h00);
        `CHK(channel_mode_o[1:0], 2'h1)
        @(posedge clk_i);
        counter_value_i <= 16'h1234;
        pulse(6'h01, 1'b0, 1'b0);
        `CHK(channel_event_flag_o[0], 1'b1)
        ahb_read(channel_value_reg(0), rd);
        `CHK(rd, 32'h0000_1234)
        ahb_write(channel_value_reg(0), 32'hffff_5555, 6'h00);
        ahb_read(channel_value_reg(0), rd);
        `CHK(rd, 32'h0000_1234)
        `CHK(match_value_o[15:0], 16'h1234)
    endtask : t_capture

    // Compare and PWM writes wait in the buffer until the update point
    task automatic t_compare;
        ahb_write(chcs(1), 32'(tcv_pkg::TCV_MODE_COMPARE) << `TCV_MODE_LSB, 6'h00);
        ahb_write(chcs(2), 32'(tcv_pkg::TCV_MODE_PWM) << `TCV_MODE_LSB, 6'h00);
        ahb_write(channel_value_reg(1), 32'habcd_9876, 6'h00);
        ahb_write(channel_value_reg(2), 32'h5a5a_ffff, 6'h00);
        `CHK(match_value_o[31:16], 16'h0000)
        `CHK(match_value_o[47:32], 16'h0000)
        pulse(6'h00, 1'b0, 1'b0);
        `CHK(match_value_o[31:16], 16'h0000)
        pulse(6'h00, 1'b0, 1'b1);
        `CHK(match_value_o[31:16], 16'h9876)
        `CHK(match_value_o[47:32], 16'hffff)
        ahb_read(channel_value_reg(1), rd);
        `CHK(rd, 32'h0000_9876)
        ahb_read(channel_value_reg(2), rd);
        `CHK(rd, 32'h0000_ffff)
    endtask : t_compare

    task automatic t_flags;
        pulse(6'h3f, 1'b1, 1'b0);
        ahb_read(`TCV_STATUS_OFF, rd);
        `CHK(rd, 32'h0000_013f)
        `CHK(counter_wrap_flag_o, 1'b1)
        ahb_write(`TCV_STATUS_OFF, 32'h0000_0000, 6'h00);
        `CHK(channel_event_flag_o, 6'h3f)
        ahb_write(`TCV_STATUS_OFF, 32'h0000_0001, 6'h00);
        `CHK(channel_event_flag_o, 6'h3e)
        ahb_write(chcs(5), 32'h0000_0080, 6'h00);
        `CHK(channel_event_flag_o, 6'h1e)
        ahb_read(chcs(4), rd);
        `CHK(rd[`TCV_CHF_BIT], 1'b1)
        ahb_write(`TCV_STATUS_OFF, 32'hffff_ffff, 6'h00);
        `CHK(channel_event_flag_o, 6'h00)
        ahb_read(`TCV_STATUS_OFF, rd);
        `CHK(rd, 32'h0000_0000)
        pulse(6'h00, 1'b1, 1'b0);
        `CHK(counter_wrap_flag_o, 1'b1)
        ahb_write(`TCV_CTRL_OFF, 32'h0000_0080, 6'h00);
        `CHK(counter_wrap_flag_o, 1'b0)
        ahb_read(`TCV_STATUS_OFF, rd);
        `CHK(rd[`TCV_WRAP_STAT_BIT], 1'b0)
    endtask : t_flags

    // A fresh event during the clearing write keeps the flag set
    task automatic t_event_race;
        pulse(6'h05, 1'b0, 1'b0);
        ahb_write(`TCV_STATUS_OFF, 32'h0000_0005, 6'h01);
        `CHK(channel_event_flag_o, 6'h01)
    endtask : t_event_race

    // The counter outside is never started here, so select changes are allowed
    task automatic t_trigger;
        for (int i = 0; i < 16; i++) begin
            ahb_write(`TCV_TIMER_SETUP_OFF, {4'hf, 4'(i), 24'hffffff}, 6'h00);
            `CHK(trigger_source_select_o, 4'(i))
            ahb_read(`TCV_TIMER_SETUP_OFF, rd);
            `CHK(rd[27:19], {4'(i), 5'h00})
        end
    endtask : t_trigger

    // A second reset mid-run returns every register to its reset value
    task automatic t_reset_again;
        @(posedge clk_i);
        reset_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        reset_i <= 1'b0;
        #1;
        `CHK(trigger_source_select_o, 4'h0)
        `CHK(match_value_o[15:0], 16'h0000)
        `CHK(channel_event_flag_o, 6'h00)
        `CHK(channel_mode_o, 12'h000)
        ahb_read(`TCV_STATUS_OFF, rd);
        `CHK(rd, 32'h0000_0000)
    endtask : t_reset_again

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge clk_i);
        reset_i <= 1'b0;
        t_reset_values();
        t_capture();
        t_compare();
        t_flags();
        t_event_race();
        t_trigger();
        t_reset_again();
        wrap_up();
    end

    // Whole sequence needs a few hundred cycles; this allows ample margin
    initial begin
        #200us;
        n_fail++;
        wrap_up();
    end
endmodule : testbench

`default_nettype wire
